// ===== verification/gpcs_pins.sv
// Pads and board outside the port
`timescale 1ns/100ps
`default_nettype none
module gpcs_pins (
    // Clock
    input  wire logic       clk,
    // Board side
    input  wire logic [7:0] drive_val,
    input  wire logic [7:0] drive_en,
    // Pad control
    input  wire logic [7:0] pullup_on,
    output logic      [7:0] pins
);
    logic [7:0] last_reg;
    always_ff @(posedge clk) begin
        last_reg <= pins;
    end
    // released pad is high only under pull-up, else it wanders
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pins[i] = drive_en[i] ? drive_val[i] : (pullup_on[i] ? 1'b1 : ~last_reg[i]);
        end
    end
endmodule
`default_nettype wire

// ===== verification/gpcs_port_props.sv
// Checker for one port configuration block
`timescale 1ns/100ps
`default_nettype none
module gpcs_port_props #(
    parameter logic [1:0] PORT_NUM = 2'd0
) (
    input wire logic        CORE_CLK,
    input wire logic        RSTN,
    input wire logic        CE,
    input wire logic        STOP_MODE,
    input wire logic [11:0] REG_ADDR,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_WDATA,
    input wire logic [7:0]  REG_RDATA,
    input wire logic        REG_HIT,
    input wire logic [7:0]  ALT_FUNCTION_ENABLE_BIT,
    input wire logic [7:0]  PIN_DIRECTION_BIT,
    input wire logic [7:0]  WEAK_PULLUP_ON,
    input wire logic [7:0]  PIN_ALT_ACTIVE,
    input wire logic [7:0]  PIN_OUTPUT_MODE,
    input wire logic [15:0] PIN_ALT_FUNC,
    input wire logic        STOP_WAKE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    logic [11:0] base;
    logic [7:0]  idx_reg;
    assign base = 12'hfd0 + {8'h00, PORT_NUM, 2'b00};
    // Own copy of the index, so control accesses can be tied to a subregister
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) idx_reg <= 8'h00;
        else if (CE && REG_WR && REG_ADDR == base) idx_reg <= REG_WDATA;
    end
    sequence pull_sel;
        CE && REG_ADDR == base + 12'h001 && idx_reg == gpcs_pkg::SUB_PULLUP;
    endsequence
    alt_active_a: assert property (PIN_ALT_ACTIVE == ALT_FUNCTION_ENABLE_BIT)
        else $error("alternate active differs from enable");
    out_mode_a: assert property (PIN_OUTPUT_MODE == (~ALT_FUNCTION_ENABLE_BIT & ~PIN_DIRECTION_BIT))
        else $error("output mode wrong");
    alt_gate_a: assert property (ALT_FUNCTION_ENABLE_BIT == 8'h00 |-> PIN_ALT_FUNC == 16'h0000)
        else $error("function selected while disabled");
    pull_write_a: assert property (pull_sel ##0 REG_WR |=> WEAK_PULLUP_ON == $past(REG_WDATA))
        else $error("pull-up write not applied");
    pull_read_a: assert property (pull_sel ##0 REG_RD |=> REG_HIT && REG_RDATA == $past(WEAK_PULLUP_ON))
        else $error("pull-up readback wrong");
    level_hit_a: assert property (CE && REG_RD && REG_ADDR == base + 12'h002 |=> REG_HIT)
        else $error("level read not answered");
    idle_read_a: assert property (CE && !REG_RD |=> !REG_HIT && REG_RDATA == 8'h00)
        else $error("answer without read");
    wake_stop_a: assert property (STOP_WAKE |-> $past(STOP_MODE))
        else $error("wake outside stop mode");
    pull_reset_a: assert property ($rose(RSTN) |-> WEAK_PULLUP_ON == 8'h00)
        else $error("pull-up reset value wrong");
endmodule
bind gpcs_port gpcs_port_props #(.PORT_NUM(PORT_NUM)) gpcs_port_props_i (.*);
`default_nettype wire

// ===== verification/tb_gpcs_port.sv
// Self-checking bench for one port configuration block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) fail_note(); end
module tb_gpcs_port;
    logic        clk = 0, rstn = 0, stop = 0, wr = 0, rd = 0, rd_d = 0, hit, wake, seen;
    logic [11:0] addr = 0;
    logic [7:0]  wd = 0, en = 0, dv = 0, de = 8'hff, rdat, pu, pins, v, s1, s2;
    logic [15:0] func;
    logic [8:0]  expq[$];
    int          miscompares = 0, checked = 0;
    // Pin 7 is absent in this variant
    gpcs_port #(.PIN_EXISTS(8'h7f)) gpcs_port_i (.CORE_CLK(clk), .RSTN(rstn), .CE(1'b1),
        .STOP_MODE(stop), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd),
        .REG_RDATA(rdat), .REG_HIT(hit), .ALT_FUNCTION_ENABLE_BIT(en),
        .PIN_DIRECTION_BIT(dv), .PIN_IN(pins), .WEAK_PULLUP_ON(pu), .PIN_ALT_ACTIVE(),
        .PIN_OUTPUT_MODE(), .PIN_ALT_FUNC(func), .STOP_WAKE(wake));
    gpcs_pins gpcs_pins_i (.clk(clk), .drive_val(dv), .drive_en(de), .pullup_on(pu), .pins(pins));
    initial forever #5 clk = ~clk;
    task automatic fail_note;
        miscompares++;
        $display("[FAIL] %0t result differs", $time);
    endtask
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) `CHK({hit, rdat}, expq.pop_front())
    end
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        wr = w;
        rd = !w;
        addr = a;
        wd = d;
        if (!w) expq.push_back({a != 12'hfd3, d});
        @(posedge clk) #1;
        wr = 0;
        rd = 0;
    endtask
    task automatic wake_win(input logic exp);
        seen = 0;
        repeat (8) @(posedge clk) seen = seen | wake;
        `CHK(seen, exp)
        // Hand back just after the edge so the caller's next change lands off it
        #1;
    endtask
    task automatic finish_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        v = 8'($urandom(32'h95a5));
        repeat (3) @(posedge clk);
        #1 rstn = 1;
        for (int i = 5; i < 9; i++) begin
            acc(1, 12'hfd0, 8'(i));
            acc(0, 12'hfd1, 8'h00);
        end
        acc(0, 12'hfd3, 8'h00);
        $display("reset values done");
        for (int i = 5; i < 9; i++) begin
            v = 8'($urandom);
            acc(1, 12'hfd0, 8'(i));
            acc(1, 12'hfd1, v);
            acc(0, 12'hfd1, v);
            if (i == 6) `CHK(pu, v)
            if (i == 7) s1 = v;
            if (i == 8) s2 = v;
        end
        $display("read write done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) #1;
            en = 8'($urandom);
            #1;
            for (int i = 0; i < 8; i++) `CHK(func[2*i+:2], en[i] ? {s2[i], s1[i]} : 2'b00)
        end
        $display("alternate select done");
        dv = 8'($urandom);
        repeat (4) @(posedge clk);
        acc(0, 12'hfd2, dv & 8'h7f);
        acc(1, 12'hfd0, 8'h06);
        acc(1, 12'hfd1, 8'hff);
        de = 8'h00;
        acc(1, 12'hfd2, 8'h00);
        acc(0, 12'hfd2, 8'h7f);
        de = 8'hff;
        $display("pin levels done");
        acc(1, 12'hfd0, 8'h05);
        acc(1, 12'hfd1, 8'h01);
        dv[0] = ~dv[0];
        wake_win(1'b0);
        stop = 1;
        dv[1] = ~dv[1];
        wake_win(1'b0);
        dv[0] = ~dv[0];
        wake_win(1'b1);
        stop = 0;
        $display("stop wake done");
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule
`default_nettype wire

// ===== verilog/gpcs_pin_sync.sv
// Two-stage synchroniser and edge-change detector for the port pins
`timescale 1ns/100ps
`default_nettype none
module gpcs_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_level,
    output logic      [WIDTH-1:0] pin_change
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] last_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else if (ce) begin
            meta_reg <= pin_async;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign pin_level  = sync_reg;
    assign pin_change = sync_reg ^ last_reg;
endmodule
`default_nettype wire

// ===== verilog/gpcs_pkg.sv
// Constants for the port pin configuration subregister block
package gpcs_pkg;
    localparam logic [11:0] ADDR_PORT_A_LEVELS = 12'hfd2;
    localparam logic [11:0] ADDR_PORT_B_LEVELS = 12'hfd6;
    localparam logic [11:0] ADDR_PORT_C_LEVELS = 12'hfda;
    // Per port: index register, then control register one byte above
    localparam logic [11:0] ADDR_INDEX_OFS     = 12'h001;
    localparam logic [11:0] ADDR_PORT_A_BASE   = 12'hfd0;
    localparam logic [11:0] ADDR_PORT_STRIDE   = 12'h004;
    localparam logic [7:0]  SUB_STOP_WAKE      = 8'h05;
    localparam logic [7:0]  SUB_PULLUP         = 8'h06;
    localparam logic [7:0]  SUB_ALT_ONE        = 8'h07;
    localparam logic [7:0]  SUB_ALT_TWO        = 8'h08;
    localparam logic [7:0]  RST_STOP_WAKE      = 8'h00;
    localparam logic [7:0]  RST_PULLUP_ABC     = 8'h00;
    localparam logic [7:0]  RST_PULLUP_D       = 8'h01;
    localparam logic [7:0]  RST_PULLUP_SMALL_A = 8'h04;
    localparam logic [7:0]  RST_ALT_ONE        = 8'h00;
    localparam logic [7:0]  RST_ALT_TWO_LARGE  = 8'h00;
    localparam logic [7:0]  RST_ALT_TWO_SMALL  = 8'h04;
    localparam logic [7:0]  RST_INDEX          = 8'h00;
    typedef enum logic [1:0] {
        PKG_LARGE = 2'b00,
        PKG_SMALL = 2'b01
    } gpcs_pkg_variant_t;
endpackage

// ===== verilog/gpcs_port.sv
// One 8-bit port: indexed configuration subregisters and pin level sampling
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Enabled pin change in stop wakes device
// - Disabled pin never wakes device
// - Index 06H selects pull-up subregister
// - Pull-up bit drives weak pull-up on pin
// - Pull-up reset 00H, 01H D, 04H small A
// - Index 07H selects alternate select one
// - Alternate select acts only when enabled
// - Index 08H selects alternate select two
// - Select two reset 00H, 04H small A
// - Read-only pin levels at FD2H/FD6H/FDAH
// - Missing pins read as zero
// - Bit x belongs to pin x
// - Enable 0 normal, 1 alternate controls
// - Index 05H selects stop wake subregister
module gpcs_port #(
    parameter int                       WIDTH      = 8,
    parameter logic [1:0]               PORT_NUM   = 2'd0,
    parameter gpcs_pkg::gpcs_pkg_variant_t VARIANT = gpcs_pkg::PKG_LARGE,
    parameter logic [7:0]               PIN_EXISTS = 8'hff,
    // Function code per pin: {code for sel=11, 10, 01, 00}, 2 bits each
    parameter logic [63:0]              ALT_MAP    = 64'he4e4_e4e4_e4e4_e4e4
) (
    // Clock and control
    input  wire logic             CORE_CLK,
    input  wire logic             RSTN,
    input  wire logic             CE,
    input  wire logic             STOP_MODE,
    // Register bus
    input  wire logic [11:0]      REG_ADDR,
    input  wire logic             REG_WR,
    input  wire logic             REG_RD,
    input  wire logic [7:0]       REG_WDATA,
    output logic      [7:0]       REG_RDATA,
    output logic                  REG_HIT,
    // From the neighbouring enable and direction registers
    input  wire logic [WIDTH-1:0] ALT_FUNCTION_ENABLE_BIT,
    input  wire logic [WIDTH-1:0] PIN_DIRECTION_BIT,
    // Pins
    input  wire logic [WIDTH-1:0] PIN_IN,
    output logic      [WIDTH-1:0] WEAK_PULLUP_ON,
    output logic      [WIDTH-1:0] PIN_ALT_ACTIVE,
    output logic      [WIDTH-1:0] PIN_OUTPUT_MODE,
    output logic [2*WIDTH-1:0]    PIN_ALT_FUNC,
    output logic                  STOP_WAKE
);
    localparam logic [11:0] BASE = gpcs_pkg::ADDR_PORT_A_BASE
                                 + 12'(PORT_NUM) * gpcs_pkg::ADDR_PORT_STRIDE;
    localparam logic [11:0] A_LEVELS = BASE + 12'h002;
    localparam logic [11:0] A_INDEX  = BASE + gpcs_pkg::ADDR_INDEX_OFS - 12'h001;
    localparam logic [11:0] A_CTRL   = BASE + gpcs_pkg::ADDR_INDEX_OFS;
    localparam logic [7:0] PU_RST =
        (VARIANT == gpcs_pkg::PKG_SMALL && PORT_NUM == 2'd0) ? gpcs_pkg::RST_PULLUP_SMALL_A :
        (PORT_NUM == 2'd3) ? gpcs_pkg::RST_PULLUP_D : gpcs_pkg::RST_PULLUP_ABC;
    localparam logic [7:0] AS2_RST =
        (VARIANT == gpcs_pkg::PKG_SMALL && PORT_NUM == 2'd0) ? gpcs_pkg::RST_ALT_TWO_SMALL
                                                              : gpcs_pkg::RST_ALT_TWO_LARGE;

    logic [7:0]       index_reg;
    logic [WIDTH-1:0] stop_wake_source_enable_reg;
    logic [WIDTH-1:0] weak_pullup_enable_reg;
    logic [WIDTH-1:0] alt_function_select_one_reg;
    logic [WIDTH-1:0] alt_function_select_two_reg;
    logic [WIDTH-1:0] pin_level_sample;
    logic [WIDTH-1:0] pin_change;
    logic [7:0]       rdata_reg;
    logic [7:0]       rdata_next;
    logic             hit_next;
    logic             wake_reg;

    gpcs_pin_sync #(
        .WIDTH      (WIDTH)
    ) u_sync (
        .clk        (CORE_CLK),
        .rst_n      (RSTN),
        .ce         (CE),
        .pin_async  (PIN_IN),
        .pin_level  (pin_level_sample),
        .pin_change (pin_change)
    );

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            index_reg <= gpcs_pkg::RST_INDEX;
        end else if (CE && REG_WR && REG_ADDR == A_INDEX) begin
            index_reg <= REG_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            stop_wake_source_enable_reg <= WIDTH'(gpcs_pkg::RST_STOP_WAKE);
            weak_pullup_enable_reg      <= WIDTH'(PU_RST);
            alt_function_select_one_reg <= WIDTH'(gpcs_pkg::RST_ALT_ONE);
            alt_function_select_two_reg <= WIDTH'(AS2_RST);
        end else if (CE && REG_WR && REG_ADDR == A_CTRL) begin
            case (index_reg)
                gpcs_pkg::SUB_STOP_WAKE: stop_wake_source_enable_reg <= REG_WDATA[WIDTH-1:0];
                gpcs_pkg::SUB_PULLUP:    weak_pullup_enable_reg      <= REG_WDATA[WIDTH-1:0];
                gpcs_pkg::SUB_ALT_ONE:   alt_function_select_one_reg <= REG_WDATA[WIDTH-1:0];
                gpcs_pkg::SUB_ALT_TWO:   alt_function_select_two_reg <= REG_WDATA[WIDTH-1:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        hit_next   = 1'b0;
        if (REG_ADDR == A_INDEX) begin
            rdata_next = index_reg;
            hit_next   = 1'b1;
        end else if (REG_ADDR == A_CTRL) begin
            case (index_reg)
                gpcs_pkg::SUB_STOP_WAKE: rdata_next = 8'(stop_wake_source_enable_reg);
                gpcs_pkg::SUB_PULLUP:    rdata_next = 8'(weak_pullup_enable_reg);
                gpcs_pkg::SUB_ALT_ONE:   rdata_next = 8'(alt_function_select_one_reg);
                gpcs_pkg::SUB_ALT_TWO:   rdata_next = 8'(alt_function_select_two_reg);
                default:                 rdata_next = 8'h00;
            endcase
            hit_next = 1'b1;
        end else if (REG_ADDR == A_LEVELS && PORT_NUM != 2'd3) begin
            rdata_next = 8'(pin_level_sample) & PIN_EXISTS;
            hit_next   = 1'b1;
        end
    end

    // Read data registered; writes to the level register are ignored
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            rdata_reg <= 8'h00;
            REG_HIT   <= 1'b0;
        end else if (CE) begin
            rdata_reg <= REG_RD ? rdata_next : 8'h00;
            REG_HIT   <= REG_RD & hit_next;
        end
    end
    assign REG_RDATA = rdata_reg;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            wake_reg <= 1'b0;
        end else if (CE) begin
            wake_reg <= STOP_MODE && |(pin_change & stop_wake_source_enable_reg);
        end
    end
    assign STOP_WAKE = wake_reg;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            logic [1:0] sel;
            assign sel = {alt_function_select_two_reg[g], alt_function_select_one_reg[g]};
            assign WEAK_PULLUP_ON[g] = weak_pullup_enable_reg[g];
            assign PIN_ALT_ACTIVE[g] = ALT_FUNCTION_ENABLE_BIT[g];
            assign PIN_OUTPUT_MODE[g] = ~ALT_FUNCTION_ENABLE_BIT[g] & ~PIN_DIRECTION_BIT[g];
            assign PIN_ALT_FUNC[2*g +: 2] = ALT_FUNCTION_ENABLE_BIT[g]
                ? ALT_MAP[8*g + 2*sel +: 2] : 2'b00;
        end
    endgenerate
endmodule
`default_nettype wire
